/* rtl/lmc_pkg.sv */
package lmc_pkg;

  // ****************************************************************
  // Channel modes
  // ****************************************************************
  typedef enum logic [1:0] {
    LMC_POR = 2'b00,
    LMC_SLEEP = 2'b01,
    LMC_STANDBY = 2'b10,
    LMC_NORMAL = 2'b11
  } lmc_mode_type;

  // ****************************************************************
  // Structure and timing
  // ****************************************************************
  localparam int LMC_CHANNELS = 4;
  localparam int LMC_HALVES = 2;
  localparam int LMC_CLK_MHZ = 125;
  localparam int LMC_CNT_W = 24;
  localparam int LMC_SYNC_W = 3;

  // Filter times in microseconds, plain defaults
  localparam int LMC_SLEEP_ENTRY_US = 10;
  localparam int LMC_NORMAL_ENTRY_US = 10;
  localparam int LMC_BUS_WAKE_US = 150;
  localparam int LMC_TX_TIMEOUT_US = 20000;

  // Least times round up: exceeding the count is taken as "longer than"
  localparam int LMC_SLEEP_ENTRY_CYC = LMC_SLEEP_ENTRY_US * LMC_CLK_MHZ;
  localparam int LMC_NORMAL_ENTRY_CYC = LMC_NORMAL_ENTRY_US * LMC_CLK_MHZ;
  localparam int LMC_BUS_WAKE_CYC = LMC_BUS_WAKE_US * LMC_CLK_MHZ;
  localparam int LMC_TX_TIMEOUT_CYC = LMC_TX_TIMEOUT_US * LMC_CLK_MHZ;

endpackage

/* rtl/lmc_half_if.sv */
`timescale 1ns/10ps
// Per-half supervisory signals shared by the channels of one half
interface lmc_half_if;
  logic supply_good;
  logic over_temp;
  modport ctrl (output supply_good, output over_temp);
  modport chan (input supply_good, input over_temp);
endinterface

/* rtl/lmc_filter.sv */
`timescale 1ns/10ps
// Level filter: a qualified level is reported once the synchronised
// input has held one level for more than LIMIT cycles.
module lmc_filter #(
  parameter int LIMIT = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  input wire logic hold,
  output logic held_high,
  output logic held_low
);

  logic [lmc_pkg::LMC_CNT_W-1:0] count;
  logic last;
  localparam logic [lmc_pkg::LMC_CNT_W-1:0] LIM =
    lmc_pkg::LMC_CNT_W'(LIMIT);

  // Restart on each change of level, saturate one count past the limit
  always_ff @(posedge clk) begin
    if (rst || hold) begin
      count <= '0;
      last <= level;
    end else if (level != last) begin
      count <= '0; // R18
      last <= level;
    end else if (count <= LIM) begin
      count <= count + 1'b1;
    end
  end

  assign held_high = last && (count > LIM) && !hold;
  assign held_low = !last && (count > LIM) && !hold;

endmodule

/* rtl/lmc_top.sv */
`timescale 1ns/10ps
// Behaviour
// R1: Normal mode, enable low past sleep filter: go to sleep.
// R2: Sleeping channel wakes only on bus low past wake filter.
// R3: Valid remote wake moves sleep to standby at once.
// R4: Standby after wake drives rx_out low as wake flag.
// R5: Enable high in standby clears wake flag immediately.
// R6: Enable high past normal filter from sleep/standby: normal mode.
// R7: Enable low past sleep filter always selects sleep.
// R8: Transmit and receive only in normal mode; otherwise driver off.
// R9: In normal mode rx_out follows bus level.
// R10: Low tx_in drives bus dominant, high releases it.
// R11: Each channel keeps its own mode and signals.
// R12: Channels 1-2 and 3-4 form halves with own supervision.
// R13: No supply-good: half held in power-on reset, all functions off.
// R14: Supply-good rising places the half's channels in sleep.
// R15: Sleep without wake and power-on reset release rx_out.
// R16: Tx low past dominant timeout disables driver until tx rises.
// R17: After entering normal, driver waits for first high tx_in.
// R18: Filters are cycle counters restarting on every level change.
// R19: Standby holds with its flag while enable low is short.
module lmc_top #(
  parameter int TX_TIMEOUT_CYC = lmc_pkg::LMC_TX_TIMEOUT_CYC,
  parameter int BUS_WAKE_CYC = lmc_pkg::LMC_BUS_WAKE_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [lmc_pkg::LMC_HALVES-1:0] SUPPLY_GOOD,
  input wire logic [lmc_pkg::LMC_HALVES-1:0] OVER_TEMP,
  input wire logic [lmc_pkg::LMC_CHANNELS-1:0] CHANNEL_WAKE_ENABLE,
  input wire logic [lmc_pkg::LMC_CHANNELS-1:0] TX_IN,
  input wire logic [lmc_pkg::LMC_CHANNELS-1:0] BUS_LINE_IN,
  output logic [lmc_pkg::LMC_CHANNELS-1:0] BUS_LINE_OUT,
  output logic [lmc_pkg::LMC_CHANNELS-1:0] BUS_LINE_OE,
  output logic [lmc_pkg::LMC_CHANNELS-1:0] RX_OUT_OUT,
  output logic [lmc_pkg::LMC_CHANNELS-1:0] RX_OUT_OE,
  output lmc_pkg::lmc_mode_type [lmc_pkg::LMC_CHANNELS-1:0] MODE
);

  localparam int NCH = lmc_pkg::LMC_CHANNELS;
  localparam int SW = lmc_pkg::LMC_SYNC_W;
  localparam int CW = lmc_pkg::LMC_CNT_W;
  localparam logic [CW-1:0] TX_LIM = CW'(TX_TIMEOUT_CYC);

  // ****************************************************************
  // Half supervision
  // ****************************************************************
  lmc_half_if half_bus [lmc_pkg::LMC_HALVES] ();
  logic [SW-1:0] sg_sync [lmc_pkg::LMC_HALVES];
  logic [SW-1:0] ot_sync [lmc_pkg::LMC_HALVES];

  for (genvar h = 0; h < lmc_pkg::LMC_HALVES; h++) begin : g_half
    // Three-stage synchronisers; a rise counts when stages 2 and 3 are both high, a fall as soon as either is low
    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        sg_sync[h] <= '0;
        ot_sync[h] <= '0;
      end else begin
        sg_sync[h] <= {sg_sync[h][SW-2:0], SUPPLY_GOOD[h]};
        ot_sync[h] <= {ot_sync[h][SW-2:0], OVER_TEMP[h]};
      end
    end
    // Each half has its own power-on and thermal status, R12
    assign half_bus[h].supply_good = sg_sync[h][1] && sg_sync[h][2];
    assign half_bus[h].over_temp = ot_sync[h][1] && ot_sync[h][2];
  end

  // ****************************************************************
  // Channels
  // ****************************************************************
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [SW-1:0] en_s;
    logic [SW-1:0] tx_s;
    logic [SW-1:0] bus_s;
    logic en_lvl;
    logic tx_lvl;
    logic bus_lvl;
    logic sg;
    logic ot;
    lmc_pkg::lmc_mode_type mode;
    lmc_pkg::lmc_mode_type next_mode;
    logic wake_flag;
    logic tx_armed;
    logic tx_timed_out;
    logic [CW-1:0] tx_count;
    logic en_high;
    logic en_low;
    logic bus_low;
    localparam int HALF = c / (NCH / lmc_pkg::LMC_HALVES);

    // Channel pairs share one half: a failing supply on one half
    // leaves the other half's channels running, R12
    assign sg = half_bus[HALF].supply_good;
    assign ot = half_bus[HALF].over_temp;

    // Per-channel synchronisers keep each channel on its own pins, R11
    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        en_s <= '0;
        tx_s <= '1;
        bus_s <= '1;
      end else begin
        en_s <= {en_s[SW-2:0], CHANNEL_WAKE_ENABLE[c]};
        tx_s <= {tx_s[SW-2:0], TX_IN[c]};
        bus_s <= {bus_s[SW-2:0], BUS_LINE_IN[c]};
      end
    end

    // Stable levels: hold the old value until stages 2 and 3 agree
    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        en_lvl <= 1'b0;
        tx_lvl <= 1'b1;
        bus_lvl <= 1'b1;
      end else begin
        if (en_s[1] == en_s[2]) en_lvl <= en_s[2];
        if (tx_s[1] == tx_s[2]) tx_lvl <= tx_s[2];
        if (bus_s[1] == bus_s[2]) bus_lvl <= bus_s[2];
      end
    end

    // Enable filters; in power-on reset the inputs are disabled
    lmc_filter #(.LIMIT(lmc_pkg::LMC_NORMAL_ENTRY_CYC)) u_norm (
      .clk(CORE_CLK), .rst(RST), .level(en_lvl),
      .hold(mode == lmc_pkg::LMC_POR),
      .held_high(en_high), .held_low()
    );
    lmc_filter #(.LIMIT(lmc_pkg::LMC_SLEEP_ENTRY_CYC)) u_sleep (
      .clk(CORE_CLK), .rst(RST), .level(en_lvl),
      .hold(mode == lmc_pkg::LMC_POR),
      .held_high(), .held_low(en_low)
    );
    // Bus wake filter runs only while asleep
    // Holding it outside sleep means a bus already low at sleep entry
    // must still stay low for the full wake time before it counts
    lmc_filter #(.LIMIT(BUS_WAKE_CYC)) u_wake (
      .clk(CORE_CLK), .rst(RST), .level(bus_lvl),
      .hold(mode != lmc_pkg::LMC_SLEEP),
      .held_high(), .held_low(bus_low)
    );

    // Mode transitions
    always_comb begin
      next_mode = mode;
      unique case (mode)
        lmc_pkg::LMC_POR: begin
          if (sg) next_mode = lmc_pkg::LMC_SLEEP; // R14
        end
        lmc_pkg::LMC_SLEEP: begin
          if (en_high) next_mode = lmc_pkg::LMC_NORMAL; // R6
          else if (bus_low) next_mode = lmc_pkg::LMC_STANDBY; // R2 R3
        end
        lmc_pkg::LMC_STANDBY: begin
          if (en_high) next_mode = lmc_pkg::LMC_NORMAL; // R6
          else if (en_low) next_mode = lmc_pkg::LMC_SLEEP; // R7 R19
        end
        lmc_pkg::LMC_NORMAL: begin
          if (en_low) next_mode = lmc_pkg::LMC_SLEEP; // R1 R7
        end
      endcase
      if (!sg) next_mode = lmc_pkg::LMC_POR; // R13
    end

    always_ff @(posedge CORE_CLK) begin
      if (RST) mode <= lmc_pkg::LMC_POR;
      else mode <= next_mode; // R11
    end

    // Wake flag: set on remote wake, cleared at once by a high enable
    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        wake_flag <= 1'b0;
      end else if (next_mode == lmc_pkg::LMC_STANDBY &&
                   mode == lmc_pkg::LMC_SLEEP) begin
        wake_flag <= 1'b1; // R3
      end else if (mode != lmc_pkg::LMC_STANDBY || en_lvl) begin
        wake_flag <= 1'b0; // R5
      end
    end

    // Driver arming: only after tx_in seen high in normal mode
    always_ff @(posedge CORE_CLK) begin
      if (RST || mode != lmc_pkg::LMC_NORMAL) tx_armed <= 1'b0;
      else if (tx_lvl) tx_armed <= 1'b1; // R17
    end

    // Dominant timeout: counts while tx low, cleared on tx high
    // It runs in every mode, so a tx held low across a mode change
    // is still caught; only a rising tx re-arms the driver
    always_ff @(posedge CORE_CLK) begin
      if (RST || tx_lvl) begin
        tx_count <= '0; // R16
        tx_timed_out <= 1'b0;
      end else if (tx_count > TX_LIM) begin
        tx_timed_out <= 1'b1; // R16
      end else begin
        tx_count <= tx_count + 1'b1;
      end
    end

    // Open-drain outputs registered; enable high means pulling low
    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        BUS_LINE_OE[c] <= 1'b0;
        RX_OUT_OE[c] <= 1'b0;
      end else begin
        BUS_LINE_OE[c] <= (mode == lmc_pkg::LMC_NORMAL) && tx_armed &&
          !tx_lvl && !tx_timed_out && !ot; // R8 R10 R16
        unique case (mode)
          lmc_pkg::LMC_NORMAL: RX_OUT_OE[c] <= !bus_lvl; // R9
          lmc_pkg::LMC_STANDBY: RX_OUT_OE[c] <= wake_flag && !en_lvl; // R4
          default: RX_OUT_OE[c] <= 1'b0; // R15
        endcase
      end
    end

    assign BUS_LINE_OUT[c] = 1'b0;
    assign RX_OUT_OUT[c] = 1'b0;
    assign MODE[c] = mode;
  end

endmodule

/* test/lmc_bus_node.sv */
`timescale 1ns/10ps
// Far side of each channel: other nodes plus the pull-up resistors
module lmc_bus_node (
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] dev_out,
  input wire logic [3:0] node_dom,
  input wire logic [3:0] rx_oe,
  input wire logic [3:0] rx_out,
  output logic [3:0] bus,
  output logic [3:0] rx_level
);
  // Wired-AND: any dominant driver beats the pull-up
  assign bus = ~((dev_oe & ~dev_out) | node_dom);
  // Open-drain receive line idles high, never shows a stale value
  assign rx_level = ~(rx_oe & ~rx_out);
endmodule

/* test/lmc_top_monitor.sv */
`timescale 1ns/10ps
// Channel 0 checks plus power-up of channels 2 and 3; slack of a few cycles covers the synchronisers
module lmc_top_monitor #(
  parameter int TX_TIMEOUT_CYC = 400,
  parameter int BUS_WAKE_CYC = 200
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [1:0] SUPPLY_GOOD,
  input wire logic [3:0] CHANNEL_WAKE_ENABLE,
  input wire logic [3:0] TX_IN,
  input wire logic [3:0] BUS_LINE_IN,
  input wire logic [3:0] BUS_LINE_OUT,
  input wire logic [3:0] BUS_LINE_OE,
  input wire logic [3:0] RX_OUT_OUT,
  input wire logic [3:0] RX_OUT_OE,
  input wire lmc_pkg::lmc_mode_type [3:0] MODE
);
  logic [23:0] tx_low;
  logic [23:0] bus_low;
  logic [23:0] en_low;
  logic dom;
  logic flag;
  assign dom = BUS_LINE_OE[0] & ~BUS_LINE_OUT[0];
  assign flag = RX_OUT_OE[0] & ~RX_OUT_OUT[0];
  // Low run lengths of the inputs, cleared by reset
  always_ff @(posedge CORE_CLK) begin
    tx_low <= (RST || TX_IN[0]) ? 24'h00_0000 : tx_low + 24'h00_0001;
    bus_low <= (RST || BUS_LINE_IN[0]) ? 24'h00_0000 :
      bus_low + 24'h00_0001;
    en_low <= (RST || CHANNEL_WAKE_ENABLE[0]) ? 24'h00_0000 :
      en_low + 24'h00_0001;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  a_drive_normal_only: assert property (BUS_LINE_OE[0] |->
    MODE[0] == lmc_pkg::LMC_NORMAL || $past(MODE[0]) == lmc_pkg::LMC_NORMAL)
    else $error("driver on outside normal mode");
  a_por_hold: assert property ((!SUPPLY_GOOD[0]) [*6] |->
    MODE[0] == lmc_pkg::LMC_POR && !RX_OUT_OE[0] && !BUS_LINE_OE[0])
    else $error("channel active without supply");
  a_por_exit: assert property ($rose(SUPPLY_GOOD[1]) |-> ##[1:8]
    (MODE[2] == lmc_pkg::LMC_SLEEP && MODE[3] == lmc_pkg::LMC_SLEEP))
    else $error("half not asleep after supply good");
  a_wake_filter: assert property (MODE[0] == lmc_pkg::LMC_SLEEP ##1
    MODE[0] == lmc_pkg::LMC_STANDBY |-> $past(bus_low, 6) + 8 >= BUS_WAKE_CYC)
    else $error("wake on short bus low");
  a_wake_flag: assert property (MODE[0] == lmc_pkg::LMC_SLEEP ##1
    MODE[0] == lmc_pkg::LMC_STANDBY |-> ##[0:3] flag)
    else $error("wake flag missing");
  a_flag_clear: assert property ($rose(CHANNEL_WAKE_ENABLE[0]) &&
    MODE[0] == lmc_pkg::LMC_STANDBY |-> ##[1:5] !flag)
    else $error("wake flag not cleared");
  a_rx_follow: assert property ((MODE[0] == lmc_pkg::LMC_NORMAL &&
    $stable(BUS_LINE_IN[0])) [*6] |-> flag == !BUS_LINE_IN[0])
    else $error("rx does not follow bus");
  a_tx_timeout: assert property (tx_low > TX_TIMEOUT_CYC + 8 |-> !dom)
    else $error("dominant past timeout");
  a_sleep_entry: assert property (MODE[0] == lmc_pkg::LMC_NORMAL ##1
    MODE[0] == lmc_pkg::LMC_SLEEP |->
    $past(en_low, 2) + 8 >= lmc_pkg::LMC_SLEEP_ENTRY_CYC)
    else $error("early sleep entry");
endmodule
bind lmc_top lmc_top_monitor #(
  .TX_TIMEOUT_CYC(TX_TIMEOUT_CYC), .BUS_WAKE_CYC(BUS_WAKE_CYC)
) lmc_top_monitor_inst (
  .CORE_CLK(CORE_CLK), .RST(RST), .SUPPLY_GOOD(SUPPLY_GOOD),
  .CHANNEL_WAKE_ENABLE(CHANNEL_WAKE_ENABLE), .TX_IN(TX_IN),
  .BUS_LINE_IN(BUS_LINE_IN), .BUS_LINE_OUT(BUS_LINE_OUT),
  .BUS_LINE_OE(BUS_LINE_OE), .RX_OUT_OUT(RX_OUT_OUT),
  .RX_OUT_OE(RX_OUT_OE), .MODE(MODE)
);

/* test/testbench.sv */
`timescale 1ns/10ps
module testbench;
  // Short counts keep the run brief
  localparam int WAKE = 200;
  localparam int TOUT = 400;
  localparam int FILT = lmc_pkg::LMC_SLEEP_ENTRY_CYC;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] sup = 2'h0;
  logic [3:0] en = 4'h0;
  logic [3:0] tx = 4'hF;
  logic [3:0] nd = 4'h0;
  logic [1:0] ot = 2'h0;
  logic [3:0] bus, boe, bout, roe, rout, rx;
  lmc_pkg::lmc_mode_type [3:0] mode;
  int failures = 0;
  int compares = 0;
  // Clock
  always #4 clk = ~clk;
  lmc_top #(.TX_TIMEOUT_CYC(TOUT), .BUS_WAKE_CYC(WAKE)) lmc_top_inst (
    .CORE_CLK(clk), .RST(rst), .SUPPLY_GOOD(sup), .OVER_TEMP(ot),
    .CHANNEL_WAKE_ENABLE(en), .TX_IN(tx), .BUS_LINE_IN(bus),
    .BUS_LINE_OUT(bout), .BUS_LINE_OE(boe), .RX_OUT_OUT(rout),
    .RX_OUT_OE(roe), .MODE(mode));
  lmc_bus_node lmc_bus_node_inst (.dev_oe(boe), .dev_out(bout),
    .node_dom(nd), .rx_oe(roe), .rx_out(rout), .bus(bus), .rx_level(rx));
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Halves leave power-on reset one at a time
  task automatic t_power();
    chk(mode[0] === lmc_pkg::LMC_POR && roe === 4'h0, "not in reset");
    chk(boe === 4'h0, "driver on in reset");
    sup = 2'h1;
    wt(10);
    chk(mode[1] === lmc_pkg::LMC_SLEEP && mode[2] === lmc_pkg::LMC_POR,
      "half 0 wrong");
    sup = 2'h3;
    wt(10);
    chk(mode[3] === lmc_pkg::LMC_SLEEP && roe === 4'h0, "half 1 wrong");
  endtask
  // Wake by bus, then enable into normal mode and transmit
  task automatic t_wake();
    nd = 4'h1;
    wt(WAKE / 2);
    nd = 4'h0;
    wt(10);
    chk(mode[0] === lmc_pkg::LMC_SLEEP, "short pulse woke");
    nd = 4'h1;
    wt(WAKE + 20);
    nd = 4'h0;
    wt(2);
    chk(mode[0] === lmc_pkg::LMC_STANDBY && rx[0] === 1'b0, "no flag");
    chk(mode[1] === lmc_pkg::LMC_SLEEP && rx[1] === 1'b1, "neighbour");
    en = 4'h1;
    wt(6);
    chk(rx[0] === 1'b1 && mode[0] === lmc_pkg::LMC_STANDBY, "flag kept");
    en = 4'h3;
    wt(FILT / 2);
    en = 4'h1;
    wt(FILT / 2 - 200);
    tx = 4'h0;
    wt(220);
    chk(mode[0] === lmc_pkg::LMC_NORMAL, "no normal");
    chk(mode[1] === lmc_pkg::LMC_SLEEP, "short high obeyed");
    chk(bus[0] === 1'b1, "driver on before tx high");
    tx = 4'h1;
    wt(6);
    chk(bus[0] === 1'b1 && rx[0] === 1'b1, "not recessive");
    nd = 4'h1;
    wt(6);
    chk(rx[0] === 1'b0, "rx misses far dominant");
    nd = 4'h0;
    tx = 4'h0;
    wt(12);
    chk(bus[0] === 1'b0 && rx[0] === 1'b0, "not dominant");
    ot = 2'h1;
    wt(6);
    chk(bus[0] === 1'b1, "driver on while hot");
    ot = 2'h0;
    wt(TOUT);
    chk(bus[0] === 1'b1, "dominant past timeout");
    tx = 4'hF;
    wt(6);
  endtask
  // Short low is ignored, long low sends the channel to sleep
  task automatic t_sleep();
    en = 4'h0;
    wt(FILT / 2);
    en = 4'h1;
    wt(6);
    chk(mode[0] === lmc_pkg::LMC_NORMAL, "short low slept");
    en = 4'h0;
    wt(FILT + 20);
    chk(mode[0] === lmc_pkg::LMC_SLEEP && roe[0] === 1'b0, "no sleep");
    tx = 4'h0;
    wt(6);
    chk(bus[0] === 1'b1 && boe[0] === 1'b0, "sends in sleep");
  endtask
  // Main sequence
  initial begin
    wt(8);
    rst = 1'b0;
    wt(8);
    t_power();
    t_wake();
    t_sleep();
    end_of_test();
  end
  // Watchdog, well past the expected run of about 4000 cycles
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule
